// file: verilog/dpll_trim_and_phase_buildout.sv
// DPLL trim word, loop bandwidth selection and hitless phase realign control
//
// How it works
// - Everything runs on the 12.800 MHz master clock.
// - Trim word built from two byte registers.
// - One trim step is 0.0196229 ppm.
// - Trim resets to 9999 hex, zero offset.
// - Full 0..65535 trim range is accepted.
// - Loop filter corner is programmable low-pass.
// - Ten bandwidth settings, 0.1 Hz to 70 Hz.
// - Pull-in and tracking bandwidth switch automatically.
// - Reference loss selects next source, raises event.
// - Event enters temporary holdover before relock.
// - Holdover measures phase, inserts compensating offset.
// - Output phase step after event under 5 ns.
// - Realign enabled, disabled or frozen; enabled at reset.
// - Frozen keeps offset, ignores further events.
// - Auto mode: pull-in while unlocked, else tracking.
// - Enabling realign while locked raises an event.
// - Bias added in 0.101 ns steps, within 1.4 ns.
`timescale 1ns/100ps
`default_nettype none
module dpll_trim_and_phase_buildout #(
    parameter int unsigned HOLD_COUNT = trim_pkg::HOLD_CYCLES,
    parameter int unsigned REF_COUNT = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [REF_COUNT-1:0] ref_ok,
    input wire logic dpll_locked,
    input wire logic signed [trim_pkg::PHASE_W-1:0] phase_error,
    output logic [7:0] reg_rdata,
    output logic [15:0] crystal_trim_word,
    output logic [3:0] loop_bandwidth,
    output logic [1:0] selected_ref,
    output logic holdover_active,
    output logic signed [trim_pkg::PHASE_W-1:0] phase_offset,
    output logic realign_event
);
    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;
    logic [REF_COUNT-1:0] ref_ok_s;
    logic locked_s;

    // Async assert, synchronous release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Reference health arrives from the monitors asynchronously
    // A source that fails for a single cycle still triggers a switch here;
    // debouncing belongs to the activity monitors upstream
    genvar gi;
    generate
        for (gi = 0; gi < REF_COUNT; gi++) begin : g_ref_sync
            sync2 u_sync (
                .clk(clk),
                .rst_n(rst_sync_n),
                .d(ref_ok[gi]),
                .q(ref_ok_s[gi])
            );
        end
    endgenerate

    sync2 u_lock_sync (
        .clk(clk),
        .rst_n(rst_sync_n),
        .d(dpll_locked),
        .q(locked_s)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // One packed state word: next_s is built whole, then registered
    typedef struct packed {
        logic [15:0] trim;
        logic [7:0] trim_lo_pend;
        logic lo_written;
        logic auto_bw;
        logic [3:0] lock_bw;
        logic [3:0] pull_bw;
        logic realign_en;
        logic realign_frz;
        logic [4:0] bias;
        logic [1:0] sel;
        trim_pkg::realign_state_t st;
        logic [31:0] hold_cnt;
        logic signed [trim_pkg::PHASE_W-1:0] offset;
        logic [7:0] rdata;
        logic [3:0] bw_out;
        logic hold_out;
        logic event_out;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] next_ref;
    logic sel_lost;
    logic trigger;
    logic signed [trim_pkg::PHASE_W-1:0] bias_ext;
    logic [7:0] status_byte;

    // Lowest index healthy reference is the highest priority
    // Ties go to the lower index; the current source is never re-picked
    always_comb begin
        next_ref = s.sel;
        for (int i = REF_COUNT - 1; i >= 0; i--) begin
            if (ref_ok_s[i] && (2'(i) != s.sel)) begin
                next_ref = 2'(i);
            end
        end
    end

    // Loss of the selected source, and the bias widened with its sign
    assign sel_lost = !ref_ok_s[s.sel];
    assign bias_ext = {{(trim_pkg::PHASE_W-5){s.bias[4]}}, s.bias};

    // Status byte: lock, realign busy, source
    assign status_byte = {3'h0, locked_s, (s.st != trim_pkg::ST_TRACK), 1'b0, s.sel};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.event_out = 1'b0;
        trigger = 1'b0;

        // Register writes; one byte per strobe, taking effect on the next edge
        // Out-of-range values are dropped or clamped rather than stored, so a
        // read-back always shows what the loop actually uses
        if (reg_we) begin
            case (reg_addr)
                trim_pkg::ADDR_TRIM_LO: begin
                    next_s.trim_lo_pend = reg_wdata;
                    next_s.lo_written = 1'b1;
                end
                trim_pkg::ADDR_TRIM_HI: begin
                    // Whole word lands at once to avoid a mixed value
                    // A lone high write is dropped, so a stale low byte never leaks in
                    if (s.lo_written) begin
                        next_s.trim = {reg_wdata, s.trim_lo_pend};
                        next_s.lo_written = 1'b0;
                    end
                end
                trim_pkg::ADDR_BW_CTRL: next_s.auto_bw = reg_wdata[trim_pkg::AUTO_BW_BIT];
                trim_pkg::ADDR_LOCK_BW: begin
                    // Out-of-range settings are dropped
                    if (reg_wdata[3:0] < trim_pkg::BW_STEPS) begin
                        next_s.lock_bw = reg_wdata[3:0];
                    end
                end
                trim_pkg::ADDR_PULL_BW: begin
                    if (reg_wdata[3:0] < trim_pkg::BW_STEPS) begin
                        next_s.pull_bw = reg_wdata[3:0];
                    end
                end
                trim_pkg::ADDR_REALIGN: begin
                    next_s.realign_en = reg_wdata[trim_pkg::REALIGN_EN_BIT];
                    next_s.realign_frz = reg_wdata[trim_pkg::REALIGN_FRZ_BIT];
                    // Turning realign on while locked realigns now
                    if (!s.realign_en && reg_wdata[trim_pkg::REALIGN_EN_BIT] && locked_s
                        && !reg_wdata[trim_pkg::REALIGN_FRZ_BIT]) begin
                        trigger = 1'b1;
                    end
                    // Disabling drops any inserted offset
                    if (!reg_wdata[trim_pkg::REALIGN_EN_BIT]) begin
                        next_s.offset = '0;
                    end
                end
                trim_pkg::ADDR_BIAS: begin
                    // Clamp to +/-14 steps of 0.101 ns
                    if (!reg_wdata[4] && (reg_wdata[4:0] > trim_pkg::BIAS_MAX)) begin
                        next_s.bias = trim_pkg::BIAS_MAX;
                    end else if (reg_wdata[4] && (reg_wdata[4:0] < trim_pkg::BIAS_MIN)) begin
                        next_s.bias = trim_pkg::BIAS_MIN;
                    end else begin
                        next_s.bias = reg_wdata[4:0];
                    end
                end
                default: ;
            endcase
        end

        // Reference loss picks the next source
        // Losses during holdover move the source and raise the event; the sequencer ignores them
        if (sel_lost && (next_ref != s.sel)) begin
            next_s.sel = next_ref;
            next_s.event_out = 1'b1;
            trigger = 1'b1;
        end

        // Realign sequencer
        case (s.st)
            trim_pkg::ST_TRACK: begin
                // Frozen or disabled ignores events
                if (trigger && next_s.realign_en && !next_s.realign_frz) begin
                    next_s.st = trim_pkg::ST_HOLD;
                    next_s.hold_cnt = '0;
                    next_s.event_out = 1'b1;
                end
            end
            trim_pkg::ST_HOLD: begin
                // Temporary holdover lets the new input settle
                // The loop free-runs on its last frequency meanwhile; the count
                // must cover the phase detector's settling, or the reading is
                // taken from a half-settled input
                if (s.hold_cnt >= HOLD_COUNT - 1) begin
                    next_s.st = trim_pkg::ST_MEASURE;
                end else begin
                    next_s.hold_cnt = s.hold_cnt + 32'h1;
                end
            end
            trim_pkg::ST_MEASURE: begin
                // Cancel measured phase so the output does not step
                // A freeze written during holdover keeps the offset; a disable has already zeroed it
                if (next_s.realign_en && !next_s.realign_frz) begin
                    next_s.offset = (trim_pkg::PHASE_W)'(s.offset + phase_error + bias_ext);
                end
                next_s.st = trim_pkg::ST_TRACK;
            end
            default: next_s.st = trim_pkg::ST_TRACK;
        endcase

        // Holdover flag registered so the pin comes straight from a flop
        next_s.hold_out = (next_s.st != trim_pkg::ST_TRACK);

        // Bandwidth choice follows lock state
        // Lock comes from the loop itself, so the change needs no software
        if (s.auto_bw && !locked_s) begin
            next_s.bw_out = s.pull_bw;
        end else begin
            next_s.bw_out = s.lock_bw;
        end

        // Read data
        // Reads have no side effects and return zero outside a strobe
        next_s.rdata = 8'h00;
        if (reg_re) begin
            case (reg_addr)
                trim_pkg::ADDR_TRIM_LO: next_s.rdata = s.trim[7:0];
                trim_pkg::ADDR_TRIM_HI: next_s.rdata = s.trim[15:8];
                trim_pkg::ADDR_BW_CTRL: next_s.rdata = {7'h00, s.auto_bw};
                trim_pkg::ADDR_LOCK_BW: next_s.rdata = {4'h0, s.lock_bw};
                trim_pkg::ADDR_PULL_BW: next_s.rdata = {4'h0, s.pull_bw};
                trim_pkg::ADDR_REALIGN: next_s.rdata = {6'h00, s.realign_frz, s.realign_en};
                trim_pkg::ADDR_BIAS: next_s.rdata = {3'h0, s.bias};
                trim_pkg::ADDR_STATUS: next_s.rdata = status_byte;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset values: trim at zero offset, realign enabled, tracking state
    // The reset copy is released two edges after the pin, so every flop
    // leaves reset on the same edge
    // Single master clock domain
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
            s.trim <= trim_pkg::TRIM_RESET;
            s.lock_bw <= trim_pkg::LOCK_BW_RESET;
            s.pull_bw <= trim_pkg::PULL_BW_RESET;
            s.bw_out <= trim_pkg::LOCK_BW_RESET;
            s.realign_en <= 1'b1;
            s.st <= trim_pkg::ST_TRACK;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    // Flopped outputs keep pin timing independent of the decode logic
    assign reg_rdata = s.rdata;
    assign crystal_trim_word = s.trim;
    assign loop_bandwidth = s.bw_out;
    assign selected_ref = s.sel;
    assign holdover_active = s.hold_out;
    assign phase_offset = s.offset;
    assign realign_event = s.event_out;
endmodule : dpll_trim_and_phase_buildout
`default_nettype wire

// file: verilog/trim_pkg.sv
// Package of constants for the DPLL trim and hitless phase realign control
`default_nettype none
package trim_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 12_800_000;
    localparam int unsigned HOLD_US = 100;
    localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1_000) * HOLD_US / 1_000;
    localparam int unsigned SETTLE_NS = 5;

    // ------------------------------------------------------------
    // Register map (byte-wide locations)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TRIM_LO = 8'h3C;
    localparam logic [7:0] ADDR_TRIM_HI = 8'h3D;
    localparam logic [7:0] ADDR_BW_CTRL = 8'h3B;
    localparam logic [7:0] ADDR_LOCK_BW = 8'h67;
    localparam logic [7:0] ADDR_PULL_BW = 8'h69;
    localparam logic [7:0] ADDR_REALIGN = 8'h48;
    localparam logic [7:0] ADDR_BIAS = 8'h72;
    localparam logic [7:0] ADDR_STATUS = 8'h09;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [15:0] TRIM_RESET = 16'h9999;
    localparam logic [3:0] BW_STEPS = 4'hA;
    localparam logic [3:0] LOCK_BW_RESET = 4'h2;
    localparam logic [3:0] PULL_BW_RESET = 4'h6;
    localparam logic [4:0] BIAS_MAX = 5'h0E;
    localparam logic [4:0] BIAS_MIN = 5'h12;
    localparam int unsigned AUTO_BW_BIT = 0;
    localparam int unsigned REALIGN_EN_BIT = 0;
    localparam int unsigned REALIGN_FRZ_BIT = 1;
    localparam int unsigned PHASE_W = 16;

    typedef enum logic [2:0] {
        ST_TRACK = 3'h1,
        ST_HOLD = 3'h2,
        ST_MEASURE = 3'h4
    } realign_state_t;
endpackage : trim_pkg
`default_nettype wire

// file: verilog/sync2.sv
// Two-flop synchroniser for a single level
`timescale 1ns/100ps
`default_nettype none
module sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    logic meta;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sync2
`default_nettype wire

// file: sim/dpll_trim_and_phase_buildout_chk.sv
// Port checks for the trim and realign block
`timescale 1ns/100ps
`default_nettype none
module dpll_trim_and_phase_buildout_chk #(
    parameter int unsigned HOLD_COUNT = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] crystal_trim_word,
    input wire logic [3:0] loop_bandwidth,
    input wire logic [1:0] selected_ref,
    input wire logic holdover_active,
    input wire logic signed [trim_pkg::PHASE_W-1:0] phase_offset,
    input wire logic realign_event
);
    // ----
    // Properties; hold length assumes HOLD_COUNT of 4
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    int unsigned hold_len;
    // Cycles spent in holdover so far, for the bounded length checks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_len <= 0;
        end else if (holdover_active) begin
            hold_len <= hold_len + 1;
        end else begin
            hold_len <= 0;
        end
    end
    property p_trim_src; $changed(crystal_trim_word) |-> $past(reg_we && reg_addr == 8'h3D); endproperty
    a_trim_src: assert property (p_trim_src) else $error("trim moved without high write");
    property p_trim_val; reg_we && reg_addr == 8'h3D && $past(reg_we && reg_addr == 8'h3C)
        |=> crystal_trim_word == {$past(reg_wdata), $past(reg_wdata, 2)}; endproperty
    a_trim_val: assert property (p_trim_val) else $error("trim word not the two bytes");
    property p_rd_hi; reg_re && reg_addr == 8'h3D |=> reg_rdata == $past(crystal_trim_word[15:8]); endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("trim high byte read wrong");
    property p_bw_rng; loop_bandwidth < 4'hA; endproperty
    a_bw_rng: assert property (p_bw_rng) else $error("bandwidth index out of range");
    property p_sel_ev; $changed(selected_ref) |-> realign_event; endproperty
    a_sel_ev: assert property (p_sel_ev) else $error("switch without event");
    property p_hold_ev; $rose(holdover_active) |-> realign_event; endproperty
    a_hold_ev: assert property (p_hold_ev) else $error("holdover without event");
    // Holdover must end, else the loop never relocks
    property p_hold_len; $rose(holdover_active) |-> holdover_active[*4] ##[1:3] !holdover_active; endproperty
    a_hold_len: assert property (p_hold_len) else $error("holdover length wrong");
    property p_hold_max; holdover_active |-> hold_len <= HOLD_COUNT; endproperty
    a_hold_max: assert property (p_hold_max) else $error("holdover overran its count");
    property p_hold_full; $fell(holdover_active) |-> hold_len == HOLD_COUNT + 1; endproperty
    a_hold_full: assert property (p_hold_full) else $error("holdover ended early");
    property p_ofs_src; $changed(phase_offset) |-> $past(holdover_active)
        || $past(reg_we && reg_addr == 8'h48) || $past(reg_we && reg_addr == 8'h48, 2); endproperty
    a_ofs_src: assert property (p_ofs_src) else $error("offset moved outside measure");
    c_hold: cover property (realign_event && holdover_active);
    c_skip: cover property (realign_event && !holdover_active);
    c_trim: cover property ($changed(crystal_trim_word));
endmodule : dpll_trim_and_phase_buildout_chk
`default_nettype wire

// file: sim/ref_source_model.sv
// Reference sources and loop lock as seen by the block
`timescale 1ns/100ps
`default_nettype none
module ref_source_model (
    input wire logic clk,
    input wire logic [3:0] fail_mask,
    input wire logic want_lock,
    input wire logic slow,
    input wire logic signed [15:0] ph,
    output logic [3:0] ref_ok,
    output logic dpll_locked,
    output logic signed [15:0] phase_error
);
    int cnt = 0;
    // ----
    // Sources
    // ----
    // Gap, off-frequency and dead input all drop the healthy level; lock lost on any change
    // Outputs are unknown until the first edge, well inside the bench's reset
    always @(posedge clk) begin
        ref_ok <= ~fail_mask;
        phase_error <= ph;
        if (!want_lock || ref_ok != ~fail_mask) begin
            cnt <= slow ? 12 : 3;
            dpll_locked <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            dpll_locked <= 1'b1;
        end
    end
endmodule : ref_source_model
`default_nettype wire

// file: sim/dpll_trim_and_phase_buildout_bench.sv
// Self-checking bench for the trim and realign block
`timescale 1ns/100ps
`default_nettype none
module dpll_trim_and_phase_buildout_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] fail_mask = 4'h0;
    logic want_lock = 1'b0;
    logic slow = 1'b1;
    logic signed [15:0] ph = 16'sh0000;
    wire [3:0] ref_ok;
    wire dpll_locked;
    wire signed [15:0] phase_error;
    wire [7:0] reg_rdata;
    wire [15:0] crystal_trim_word;
    wire [3:0] loop_bandwidth;
    wire [1:0] selected_ref;
    wire holdover_active;
    wire signed [15:0] phase_offset;
    wire realign_event;
    logic [7:0] exp_q[$];
    logic re_seen = 1'b0;
    int fails = 0;
    int n_checks = 0;
    int seed = 33;
    logic [7:0] r;
    logic signed [15:0] e;
    // ----
    // Harness
    // ----
    initial begin
        forever #20 clk = ~clk;
    end
    dpll_trim_and_phase_buildout #(.HOLD_COUNT(4), .REF_COUNT(4)) i_dpll_trim_and_phase_buildout (
        .clk(clk), .rst_n(rst_n), .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .ref_ok(ref_ok), .dpll_locked(dpll_locked), .phase_error(phase_error),
        .reg_rdata(reg_rdata), .crystal_trim_word(crystal_trim_word), .loop_bandwidth(loop_bandwidth),
        .selected_ref(selected_ref), .holdover_active(holdover_active), .phase_offset(phase_offset),
        .realign_event(realign_event));
    ref_source_model i_ref_source_model (.clk(clk), .fail_mask(fail_mask), .want_lock(want_lock),
        .slow(slow), .ph(ph), .ref_ok(ref_ok), .dpll_locked(dpll_locked), .phase_error(phase_error));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task automatic ck(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : ck
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    // Low then high byte on back-to-back edges, as the pairing expects
    task automatic wr_trim(input logic [15:0] w);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= 8'h3C;
        reg_wdata <= w[7:0];
        @(posedge clk);
        reg_addr <= 8'h3D;
        reg_wdata <= w[15:8];
        @(posedge clk);
        reg_we <= 1'b0;
        @(negedge clk);
    endtask : wr_trim
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(x);
        @(posedge clk);
        reg_re <= 1'b0;
    endtask : rd
    // Read data is valid one cycle after the strobe only
    always @(posedge clk) begin
        re_seen <= reg_re;
        if (re_seen) begin
            ck(reg_rdata, exp_q.pop_front());
        end
    end
    task automatic wait_ev();
        int i;
        @(negedge clk);
        for (i = 0; i < 40 && realign_event !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 40) begin
            fails++;
            $display("[ERR] %0t no realign event", $time);
            close_out();
        end
    endtask : wait_ev
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        ck(crystal_trim_word, 16'h9999);
        ck(loop_bandwidth, 16'h0002);
        rd(8'h3D, 8'h99);
        rd(8'h48, 8'h01);
        $display("done: reset");
        wr_trim(16'h989A);
        ck(crystal_trim_word, 16'h989A);
        r = 8'($random(seed));
        wr(8'h3D, r);
        repeat (2) @(negedge clk);
        ck(crystal_trim_word, 16'h989A);
        for (int k = 0; k < 2; k++) begin
            wr_trim({16{k[0]}});
            ck(crystal_trim_word, {16{k[0]}});
        end
        rd(8'h3D, 8'hFF);
        $display("done: trim");
        r = 8'($unsigned($random(seed)) % 10);
        wr(8'h69, r);
        wr(8'h67, 8'h07);
        wr(8'h67, 8'h0A);
        rd(8'h67, 8'h07);
        wr(8'h3B, 8'h00);
        repeat (2) @(negedge clk);
        ck(loop_bandwidth, 16'h0007);
        wr(8'h3B, 8'h01);
        repeat (2) @(negedge clk);
        ck(loop_bandwidth, {8'h00, r});
        @(posedge clk);
        want_lock <= 1'b1;
        repeat (20) @(negedge clk);
        ck(loop_bandwidth, 16'h0007);
        $display("done: bandwidth");
        wr(8'h72, 8'h0F);
        rd(8'h72, 8'h0E);
        wr(8'h72, 8'h03);
        @(posedge clk);
        ph <= 16'($random(seed) % 500);
        fail_mask <= 4'h1;
        slow <= 1'b0;
        wait_ev();
        e = ph + 16'sh0003;
        ck(selected_ref, 16'h0001);
        ck(holdover_active, 16'h0001);
        repeat (8) @(negedge clk);
        ck(holdover_active, 16'h0000);
        ck(phase_offset, e);
        rd(8'h09, 8'h11);
        wr(8'h48, 8'h03);
        @(posedge clk);
        fail_mask <= 4'h3;
        wait_ev();
        ck(holdover_active, 16'h0000);
        repeat (8) @(negedge clk);
        ck(phase_offset, e);
        wr(8'h48, 8'h00);
        @(posedge clk);
        fail_mask <= 4'h7;
        wait_ev();
        ck(selected_ref, 16'h0003);
        ck(holdover_active, 16'h0000);
        repeat (12) @(negedge clk);
        ck(phase_offset, 16'h0000);
        wr(8'h48, 8'h01);
        wait_ev();
        ck(holdover_active, 16'h0001);
        repeat (8) @(negedge clk);
        ck(phase_offset, e);
        $display("done: realign");
        close_out();
    end
endmodule : dpll_trim_and_phase_buildout_bench
bind dpll_trim_and_phase_buildout dpll_trim_and_phase_buildout_chk #(.HOLD_COUNT(HOLD_COUNT)) i_chk (
    .clk(clk), .rst_n(rst_n), .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .crystal_trim_word(crystal_trim_word), .loop_bandwidth(loop_bandwidth),
    .selected_ref(selected_ref), .holdover_active(holdover_active), .phase_offset(phase_offset),
    .realign_event(realign_event));
`default_nettype wire
